// ### core/wsc_break_tx.sv
`default_nettype none
module wsc_break_tx
   import wsc_pkg::*;
#(
   parameter int unsigned BT_CYC = BT_X1_CYC
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic [1:0] speed,
   // Line drive and status
   output logic pull_low_q,
   output logic done_q
);
   localparam logic [31:0] BRK_X1_CYC = 32'((64'(BT_CYC) * BRK_NUM) / BRK_DEN);
   logic [31:0] len;
   logic [31:0] cnt_q;
   assign len = wsc_scale(BRK_X1_CYC, speed);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pull_low_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 32'h0;
      end else begin
         done_q <= 1'b0;
         if (start && !pull_low_q) begin
            pull_low_q <= 1'b1;
            cnt_q <= 32'h1;
         end else if (pull_low_q) begin
            cnt_q <= cnt_q + 32'h1;
            if (cnt_q >= len) begin
               pull_low_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
   property p_brk_len;
      @(posedge clk_sys) disable iff (rst)
         pull_low_q |=> pull_low_q == ($past(cnt_q) < $past(len));
   endproperty
   a_brk_len: assert property (p_brk_len) else $error("break width wrong");
endmodule // wsc_break_tx
`default_nettype wire

// ### core/wsc_otp_mem.sv
`default_nettype none
module wsc_otp_mem
   import wsc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pair write, even address
   input wire logic wr_en,
   input wire logic [2:0] wr_pair,
   input wire logic [15:0] wr_data,
   // Configuration read
   output logic [7:0] cfg_byte,
   output logic [7:0] trim_byte
);
   logic [7:0] mem_q [OTP_BYTES];
   logic [3:0] lo_addr;
   logic grp1_hit;
   logic grp0_hit;
   logic wr_ok;
   assign lo_addr = {wr_pair, 1'b0};
   assign grp1_hit = (lo_addr >= OTP_GRP1_LO) && (lo_addr <= OTP_GRP1_HI);
   assign grp0_hit = (lo_addr >= OTP_GRP0_LO) && (lo_addr <= OTP_GRP0_HI);
   assign wr_ok = wr_en && !(grp1_hit && mem_q[OTP_ADDR_CFG][CFG_LOCK1_BIT])
                  && !(grp0_hit && mem_q[OTP_ADDR_CFG][CFG_LOCK0_BIT]);
   assign cfg_byte = mem_q[OTP_ADDR_CFG];
   assign trim_byte = mem_q[OTP_ADDR_TRIM];
   // Storage; trim byte is read-only so its half of a write is dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < OTP_BYTES; i++) begin
            mem_q[i] <= OTP_ERASED;
         end
      end else if (wr_ok) begin
         mem_q[lo_addr] <= wr_data[7:0];
         if (lo_addr != OTP_ADDR_CFG) begin
            mem_q[lo_addr + 4'h1] <= wr_data[15:8];
         end
      end
   end
endmodule // wsc_otp_mem
`default_nettype wire

// ### core/wsc_power_ctrl.sv
`default_nettype none
module wsc_power_ctrl
   import wsc_pkg::*;
#(
   parameter int unsigned WAKE_CYC_P = WAKE_CYC,
   parameter int unsigned ASLEEP_CYC_P = ASLEEP_CYC,
   parameter int unsigned EEW_CYC_P = EEW_CYC,
   parameter int unsigned BT_CYC_P = BT_X1_CYC
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Single-wire line, open drain
   input wire logic single_wire_line_i,
   output logic single_wire_line_o,
   output logic single_wire_line_oe,
   // Events from the frame decoder
   input wire logic sleep_op,
   input wire logic soft_reset,
   input wire logic challenge_done,
   input wire logic otp_wr_en,
   input wire logic [2:0] otp_wr_pair,
   input wire logic [15:0] otp_wr_data,
   // Auto-sleep control bit write
   input wire logic auto_sleep_wr,
   input wire logic auto_sleep_val,
   // State towards the rest of the chip
   output logic regulator_on_q,
   output logic logic_reset_q,
   output logic bus_ready_q,
   output logic line_rx_q,
   output logic hash_start_q,
   output logic auth_ready_q,
   output logic auto_sleep_enable_q,
   output logic [7:0] master_control_reg_q,
   output logic [7:0] status_reg_q,
   output logic [1:0] dev_address_q,
   output logic [1:0] speed_q
);
   wsc_state_type state_q;
   wsc_state_type state_d;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic [31:0] idle_q;
   logic [31:0] bt_cnt_q;
   logic line_prev_q;
   logic srst_q;
   logic fetch_q;
   logic brk_start;
   logic brk_low;
   logic brk_done;
   logic line_fall;
   logic line_edge;
   logic [7:0] cfg_byte;
   logic [7:0] trim_byte;
   logic drive_low_q;
   logic bt_tick;
   logic [31:0] bt_len;
   logic auto_sleep_enable_hit;
   logic cnt_keep;

   // Configuration storage
   wsc_otp_mem u_otp (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr_en(otp_wr_en && state_q == ST_IDLE),
      .wr_pair(otp_wr_pair),
      .wr_data(otp_wr_data),
      .cfg_byte(cfg_byte),
      .trim_byte()
   );

   // Break generator
   wsc_break_tx #(
      .BT_CYC(BT_CYC_P)
   ) u_brk (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(brk_start),
      .speed(speed_q),
      .pull_low_q(brk_low),
      .done_q(brk_done)
   );

   // Edge detection on the sampled line
   assign line_fall = line_prev_q && !single_wire_line_i;
   assign line_edge = line_prev_q != single_wire_line_i;
   assign brk_start = (state_q == ST_BREAK) && !brk_low && !brk_done;
   assign bt_len = wsc_scale(32'(BT_CYC_P), speed_q);
   assign bt_tick = bt_cnt_q >= bt_len - 32'h1;
   assign auto_sleep_enable_hit = auto_sleep_enable_q && (idle_q >= 32'(ASLEEP_CYC_P) - 32'h1);
   // timing runs on from the fall through wake and fetch
   // Wake and fetch keep the deglitch count, so release is measured from the host fall
   assign cnt_keep = state_d == state_q || state_d == ST_WAKE || state_d == ST_FETCH || state_d == ST_BREAK;

   // Next-state logic
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 32'h1;
      case (state_q)
         ST_SLEEP: begin
            cnt_d = 32'h0;
            // low must last the deglitch time
            if (!single_wire_line_i && (line_fall || cnt_q != 32'h0)) begin
               cnt_d = cnt_q + 32'h1;
               if (cnt_q >= 32'(DEGLITCH_CYC) - 32'h1) begin
                  state_d = ST_WAKE;
               end
            end
         end
         ST_WAKE: begin
            if (cnt_q >= 32'(POR_REL_CYC) - 32'h1) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (fetch_q) begin
               state_d = srst_q ? ST_BREAK : ST_WAIT_RDY;
            end
         end
         ST_WAIT_RDY: begin
            if (cnt_q >= 32'(WAKE_CYC_P) - 32'h1) begin
               state_d = ST_BREAK;
            end
         end
         ST_BREAK: begin
            if (brk_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            cnt_d = 32'h0;
            if (soft_reset) begin
               state_d = ST_FETCH;
            end else if (sleep_op) begin
               state_d = ST_SLP_WAIT;
            end else if (otp_wr_en) begin
               state_d = ST_OTP_WR;
            end else if (auto_sleep_enable_hit) begin
               state_d = ST_SLEEP;
            end
         end
         ST_OTP_WR: begin
            if (cnt_q >= 32'(EEW_CYC_P) - 32'h1) begin
               state_d = ST_IDLE;
            end
         end
         ST_SLP_WAIT: begin
            if (cnt_q >= 32'(SLP_WAIT_CYC) - 32'h1) begin
               state_d = ST_SLEEP;
               cnt_d = 32'h0;
            end
         end
         default: begin
            state_d = ST_SLEEP;
            cnt_d = 32'h0;
         end
      endcase
   end

   // State and timer; all delays counted on clk_sys
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_SLEEP;
         cnt_q <= 32'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_keep ? cnt_d : 32'h0;
      end
   end

   // Fetch sequencing: one cycle to present the bytes, one to load them
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fetch_q <= 1'b0;
         srst_q <= 1'b0;
      end else begin
         fetch_q <= (state_q == ST_FETCH) && !fetch_q;
         if (state_q == ST_IDLE && soft_reset) begin
            srst_q <= 1'b1;
         end else if (state_q == ST_SLEEP || state_q == ST_WAKE) begin
            srst_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         master_control_reg_q <= 8'h00;
         status_reg_q <= 8'h00;
         dev_address_q <= 2'h0;
         speed_q <= 2'h1;
         auto_sleep_enable_q <= 1'b0;
      end else if (state_q == ST_FETCH && fetch_q) begin
         master_control_reg_q <= cfg_byte;
         status_reg_q <= {4'h0, cfg_byte[CFG_EINT_BIT], cfg_byte[CFG_AUTO_SLEEP_ENABLE_BIT],
                          cfg_byte[CFG_LOCK1_BIT], cfg_byte[CFG_LOCK0_BIT]};
         dev_address_q <= cfg_byte[CFG_DAB_LSB +: 2];
         speed_q <= cfg_byte[CFG_SPD_LSB +: 2];
         auto_sleep_enable_q <= cfg_byte[CFG_AUTO_SLEEP_ENABLE_BIT];
      end else if (auto_sleep_wr && state_q == ST_IDLE) begin
         // Software may clear the enable, and set it only where the configuration grants it
         auto_sleep_enable_q <= auto_sleep_val && cfg_byte[CFG_AUTO_SLEEP_ENABLE_BIT];
         master_control_reg_q[CFG_AUTO_SLEEP_ENABLE_BIT] <= auto_sleep_val && cfg_byte[CFG_AUTO_SLEEP_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regulator_on_q <= 1'b0;
         logic_reset_q <= 1'b1;
         bus_ready_q <= 1'b0;
      end else begin
         regulator_on_q <= state_d != ST_SLEEP;
         logic_reset_q <= state_d == ST_SLEEP || state_d == ST_WAKE;
         bus_ready_q <= state_d == ST_IDLE;
      end
   end

   // idle counter, cleared by any line edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         idle_q <= 32'h0;
         // Idle level of the pulled-up line, so no false edge follows reset
         line_prev_q <= 1'b1;
      end else begin
         line_prev_q <= single_wire_line_i;
         if (line_edge || state_q != ST_IDLE) begin
            idle_q <= 32'h0;
         end else if (!auto_sleep_enable_hit) begin
            idle_q <= idle_q + 32'h1;
         end
      end
   end

   // hash start, and result ready one bit-time later, held while idle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hash_start_q <= 1'b0;
         auth_ready_q <= 1'b0;
         bt_cnt_q <= 32'h0;
      end else begin
         hash_start_q <= challenge_done && state_q == ST_IDLE;
         if (hash_start_q) begin
            bt_cnt_q <= 32'h1;
            auth_ready_q <= 1'b0;
         end else if (bt_cnt_q != 32'h0) begin
            bt_cnt_q <= bt_tick ? 32'h0 : bt_cnt_q + 32'h1;
            auth_ready_q <= bt_tick;
         end else if (state_q != ST_IDLE) begin
            auth_ready_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_rx_q <= 1'b1;
         drive_low_q <= 1'b0;
      end else begin
         // While idle every low pulse is handed on as a bit, however narrow
         line_rx_q <= (state_q == ST_IDLE) ? single_wire_line_i : 1'b1;
         drive_low_q <= 1'b0;
      end
   end
   assign single_wire_line_o = drive_low_q;
   // enable high only while pulling low
   assign single_wire_line_oe = brk_low;

   // no wake without a low line
   property p_stay_asleep;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_SLEEP && single_wire_line_i) |=> state_q == ST_SLEEP;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep) else $error("woke with line high");

   property p_deglitch;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_SLEEP && line_fall) ##1 single_wire_line_i |-> ##1 state_q == ST_SLEEP;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("glitch woke block");

   property p_por_release;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_WAKE && state_d == ST_FETCH) |-> cnt_q == 32'(POR_REL_CYC) - 32'h1;
   endproperty
   a_por_release: assert property (p_por_release) else $error("reset release off");

   property p_fetch_first;
      @(posedge clk_sys) disable iff (rst)
         state_q == ST_FETCH |=> !bus_ready_q;
   endproperty
   a_fetch_first: assert property (p_fetch_first) else $error("ready before fetch");

   // ready break time from the start of the ready wait
   property p_wake_time;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_WAIT_RDY && state_d == ST_BREAK) |-> ##2 brk_low && cnt_q == 32'(WAKE_CYC_P) + 32'h1;
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("ready break late");

   // regulator kept on after sleep opcode
   property p_slp_hold;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_SLP_WAIT && state_d == ST_SLEEP) |-> cnt_q >= 32'(SLP_WAIT_CYC) - 32'h1 && regulator_on_q;
   endproperty
   a_slp_hold: assert property (p_slp_hold) else $error("regulator cut early");

   property p_srst_break;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_IDLE && soft_reset) |-> ##[1:8] brk_low;
   endproperty
   a_srst_break: assert property (p_srst_break) else $error("soft reset break late");

   // hash starts right after the challenge
   property p_hash_start;
      @(posedge clk_sys) disable iff (rst)
         (challenge_done && state_q == ST_IDLE) |=> hash_start_q;
   endproperty
   a_hash_start: assert property (p_hash_start) else $error("hash start missing");

   property p_otp_busy;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_OTP_WR && state_d == ST_IDLE) |-> cnt_q == 32'(EEW_CYC_P) - 32'h1;
   endproperty
   a_otp_busy: assert property (p_otp_busy) else $error("write busy time off");

   property p_drive_awake;
      @(posedge clk_sys) disable iff (rst)
         single_wire_line_oe |-> regulator_on_q && !single_wire_line_o;
   endproperty
   a_drive_awake: assert property (p_drive_awake) else $error("drive while asleep");
endmodule // wsc_power_ctrl
`default_nettype wire

// ### include/wsc_pkg.sv
`default_nettype none
package wsc_pkg;
   // Clock
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
   // Times in their own units
   localparam int unsigned DEGLITCH_US = 10;
   localparam int unsigned POR_REL_US = 20;
   localparam int unsigned WAKE_US = 160;
   localparam int unsigned SLP_WAIT_US = 4;
   localparam int unsigned ASLEEP_MS = 600;
   localparam int unsigned EEW_US = 1800;
   localparam int unsigned SRST_MAX_US = 30;
   localparam int unsigned BIT_RATE_X1_HZ = 5780;
   localparam int unsigned BRK_NUM = 1391;
   localparam int unsigned BRK_DEN = 1000;
   // Derived cycle counts
   localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
   localparam int unsigned POR_REL_CYC = POR_REL_US * CLK_MHZ;
   localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
   localparam int unsigned SLP_WAIT_CYC = SLP_WAIT_US * CLK_MHZ;
   localparam int unsigned ASLEEP_CYC = ASLEEP_MS * 1000 * CLK_MHZ;
   localparam int unsigned EEW_CYC = EEW_US * CLK_MHZ;
   localparam int unsigned SRST_MAX_CYC = SRST_MAX_US * CLK_MHZ;
   localparam int unsigned BT_X1_CYC = CLK_HZ / BIT_RATE_X1_HZ;
   // Memory layout, byte addresses
   localparam int unsigned OTP_BYTES = 16;
   localparam logic [3:0] OTP_ADDR_CFG = 4'h0;
   localparam logic [3:0] OTP_ADDR_TRIM = 4'h1;
   localparam logic [3:0] OTP_GRP1_LO = 4'h2;
   localparam logic [3:0] OTP_GRP1_HI = 4'h9;
   localparam logic [3:0] OTP_GRP0_LO = 4'hA;
   localparam logic [3:0] OTP_GRP0_HI = 4'hD;
   localparam logic [7:0] OTP_ERASED = 8'h00;
   // Default configuration byte fields
   localparam int unsigned CFG_LOCK0_BIT = 0;
   localparam int unsigned CFG_LOCK1_BIT = 1;
   localparam int unsigned CFG_AUTO_SLEEP_ENABLE_BIT = 2;
   localparam int unsigned CFG_EINT_BIT = 3;
   localparam int unsigned CFG_SPD_LSB = 4;
   localparam int unsigned CFG_DAB_LSB = 6;
   // Speed codes: multiplier 0.5, 1, 2, 4
   typedef enum logic [1:0] {
      SPD_HALF = 2'h0,
      SPD_X1 = 2'h1,
      SPD_X2 = 2'h2,
      SPD_X4 = 2'h3
   } wsc_speed_type;
   // One-hot power states
   typedef enum logic [7:0] {
      ST_SLEEP = 8'h01,
      ST_WAKE = 8'h02,
      ST_FETCH = 8'h04,
      ST_WAIT_RDY = 8'h08,
      ST_BREAK = 8'h10,
      ST_IDLE = 8'h20,
      ST_OTP_WR = 8'h40,
      ST_SLP_WAIT = 8'h80
   } wsc_state_type;
   // Scale a x1 count by the speed code
   function automatic logic [31:0] wsc_scale(input logic [31:0] x1, input logic [1:0] spd);
      case (spd)
         SPD_HALF: wsc_scale = {x1[30:0], 1'b0};
         SPD_X1: wsc_scale = x1;
         SPD_X2: wsc_scale = {1'b0, x1[31:1]};
         default: wsc_scale = {2'b00, x1[31:2]};
      endcase
   endfunction
endpackage
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench
   import wsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Shortened counts keep the run brief
   localparam int WK = 400;
   localparam int AS = 2000;
   localparam int EW = 300;
   localparam int BT = 40;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic line;
   logic sleep_op = 1'b0;
   logic soft_reset = 1'b0;
   logic challenge_done = 1'b0;
   logic otp_wr_en = 1'b0;
   logic [2:0] otp_wr_pair = 3'h0;
   logic [15:0] otp_wr_data = 16'h0000;
   logic auto_sleep_wr = 1'b0;
   logic auto_sleep_val = 1'b1;
   logic dev_o, dev_oe, regulator_on_q, logic_reset_q, bus_ready_q, line_rx_q;
   logic hash_start_q, auth_ready_q, auto_sleep_enable_q;
   logic [7:0] master_control_reg_q, status_reg_q;
   logic [1:0] dev_address_q, speed_q;
   int err_count = 0;
   int n_checks = 0;
   int a, b, c, n;
   // Flags watched by index: 0 oe, 1 ready, 2 reset, 3 regulator, 4 auth, 5 hash
   wire logic [5:0] obs = {hash_start_q, auth_ready_q, regulator_on_q, logic_reset_q, bus_ready_q, dev_oe};

   always #4 clk_sys = ~clk_sys;

   wsc_host_model host_u (.clk_sys(clk_sys), .dev_o(dev_o), .dev_oe(dev_oe), .line(line));

   wsc_power_ctrl #(.WAKE_CYC_P(WK), .ASLEEP_CYC_P(AS), .EEW_CYC_P(EW), .BT_CYC_P(BT)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .single_wire_line_i(line), .single_wire_line_o(dev_o),
      .single_wire_line_oe(dev_oe), .sleep_op(sleep_op), .soft_reset(soft_reset),
      .challenge_done(challenge_done), .otp_wr_en(otp_wr_en), .otp_wr_pair(otp_wr_pair),
      .otp_wr_data(otp_wr_data), .auto_sleep_wr(auto_sleep_wr), .auto_sleep_val(auto_sleep_val),
      .regulator_on_q(regulator_on_q), .logic_reset_q(logic_reset_q), .bus_ready_q(bus_ready_q),
      .line_rx_q(line_rx_q), .hash_start_q(hash_start_q), .auth_ready_q(auth_ready_q),
      .auto_sleep_enable_q(auto_sleep_enable_q), .master_control_reg_q(master_control_reg_q),
      .status_reg_q(status_reg_q), .dev_address_q(dev_address_q), .speed_q(speed_q));

   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[FAIL] t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
      end
   endtask

   // Bounded wait for a flag, counting edges
   task automatic wait_bit(input int idx, input logic v, input int lim, output int k);
      k = 0;
      while (obs[idx] !== v && k < lim) begin
         tick(1);
         k++;
      end
   endtask

   // Waking break; returns fall-to-reset-release, fall-to-break and break length
   task automatic wake(output int t_rst, output int t_oe, output int t_brk);
      int k;
      host_u.pulse(1500);
      wait_bit(2, 1'b0, 3000, k);
      t_rst = 1499 + k;
      wait_bit(0, 1'b1, WK + 3000, k);
      t_oe = t_rst + k;
      wait_bit(0, 1'b0, 400, t_brk);
      wait_bit(1, 1'b1, 10, k);
      chk_rng(k, 0, 3);
   endtask

   task automatic t_sleep_glitch();
      chk_val({regulator_on_q, logic_reset_q, bus_ready_q, dev_oe, line_rx_q, speed_q}, 16'h0025);
      host_u.pulse(1000);
      tick(1500);
      chk_val({regulator_on_q, logic_reset_q}, 16'h0001);
   endtask

   task automatic t_first_wake();
      wake(a, b, c);
      chk_rng(a, 2495, 2510);
      chk_rng(b, a + 1, 2500 + WK + 20);
      chk_rng(c, 110, 113);
      chk_val({auto_sleep_enable_q, speed_q, status_reg_q}, 16'h0000);
   endtask

   task automatic t_otp_write();
      otp_wr_data = 16'h00E4;
      otp_wr_en = 1'b1;
      tick(1);
      otp_wr_en = 1'b0;
      tick(2);
      chk_val(bus_ready_q, 16'h0000);
      wait_bit(1, 1'b1, EW + 50, n);
      chk_rng(n, EW - 5, EW + 10);
   endtask

   task automatic t_soft_reset();
      soft_reset = 1'b1;
      tick(1);
      soft_reset = 1'b0;
      wait_bit(0, 1'b1, 3750, n);
      chk_rng(n, 0, 10);
      wait_bit(0, 1'b0, 100, n);
      chk_rng(n, 26, 29);
      wait_bit(1, 1'b1, 10, n);
      chk_val({dev_address_q, speed_q}, 16'h000E);
      chk_val({auto_sleep_enable_q, status_reg_q}, 16'h0104);
      chk_val(master_control_reg_q, 16'h00E4);
   endtask

   task automatic t_hash();
      challenge_done = 1'b1;
      tick(1);
      challenge_done = 1'b0;
      wait_bit(5, 1'b1, 3, n);
      chk_rng(n, 0, 2);
      wait_bit(4, 1'b1, 40, n);
      chk_rng(n, 15, 21);
   endtask

   task automatic t_narrow_then_auto();
      fork
         host_u.pulse(30);
         begin
            tick(12);
            chk_val(line_rx_q, 16'h0000);
         end
      join
      chk_val({regulator_on_q, bus_ready_q}, 16'h0003);
      wait_bit(3, 1'b0, AS + 100, n);
      chk_rng(n, AS - 20, AS + 20);
   endtask

   task automatic t_sleep_op();
      wake(a, b, c);
      chk_val(auto_sleep_enable_q, 16'h0001);
      auto_sleep_wr = 1'b1;
      auto_sleep_val = 1'b0;
      tick(1);
      auto_sleep_wr = 1'b0;
      tick(2);
      chk_val(auto_sleep_enable_q, 16'h0000);
      chk_val(master_control_reg_q, 16'h00E0);
      sleep_op = 1'b1;
      tick(1);
      sleep_op = 1'b0;
      tick(2);
      chk_val(bus_ready_q, 16'h0000);
      wait_bit(3, 1'b0, 700, n);
      chk_rng(n, 497, 510);
   endtask

   // Main sequence: reset, then scenarios in order
   initial begin
      tick(10);
      rst = 1'b0;
      tick(1);
      t_sleep_glitch();
      t_first_wake();
      t_otp_write();
      t_soft_reset();
      t_hash();
      t_narrow_then_auto();
      t_sleep_op();
      test_done();
   end

   // Watchdog, well above the expected run of some 11500 cycles
   initial begin
      #(40000 * 8);
      err_count++;
      test_done();
   end
endmodule // testbench
`default_nettype wire

// ### tb/wsc_host_model.sv
`default_nettype none
module wsc_host_model (
   // Clock
   input wire logic clk_sys,
   // Device side of the wire
   input wire logic dev_o,
   input wire logic dev_oe,
   // Resolved wire level
   output logic line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic host_oe = 1'b0;
   // open drain with pull-up
   // Pull-up wins unless a party pulls low; no party ever drives high
   assign line = ~host_oe & (dev_oe ? dev_o : 1'b1);
   // narrow waking break
   // Holds the line low n cycles; callers keep n under 2900 so the ready break stays visible
   task automatic pulse(input int n);
      @(posedge clk_sys);
      #1 host_oe = 1'b1;
      repeat (n) @(posedge clk_sys);
      #1 host_oe = 1'b0;
   endtask
endmodule // wsc_host_model
`default_nettype wire
